// ### rtl/sda_map.vh
/*
 * constants of the serial distribution arbiter: clock rate, hold
 * times, register offsets, field positions and reset values.
 * assumes a 250 MHz system clock; times in milliseconds, with their
 * cycle counts sized to the counters that hold them.
 */
`ifndef SDA_MAP_VH
`define SDA_MAP_VH

// ==========================================================
// timing
`define SDA_CLK_KHZ     250000
`define SDA_REL_MS      4
`define SDA_IDLE_MS     10
`define SDA_STREAM_MS   3000
`define SDA_LOCK_MS     400
// the same hold times in system clock cycles
`define SDA_REL_CYC     20'd1000000
`define SDA_IDLE_CYC    22'd2500000
`define SDA_STREAM_CYC  30'd750000000
`define SDA_LOCK_CYC    27'd100000000

// ==========================================================
// register offsets (byte addresses)
`define SDA_OFS_CFG     8'h00
`define SDA_OFS_STAT    8'h04
`define SDA_OFS_ACLR    8'h08

// ==========================================================
// configuration fields, four bits each, one per channel, plus the single host DTE bit
`define SDA_CFG_DTE     0
`define SDA_CFG_STD     4
`define SDA_CFG_STRM    8
`define SDA_CFG_DD      12
`define SDA_CFG_DIS     16
`define SDA_CFG_HDTE    20
`define SDA_CFG_MASK    32'h001fffff
`define SDA_CFG_RST     32'h00000000

// ==========================================================
// status fields
`define SDA_ST_LOCK     0
`define SDA_ST_GNT      4
`define SDA_ST_GIDX     5
`define SDA_ST_ALARM    8
`define SDA_ST_ACT      12

// ==========================================================
// synchroniser reset: data lines idle at mark, handshakes off
`define SDA_SYNC_RST    22'h2cff00

`endif

// ### rtl/sda_arbiter.v
/*
 * serial distribution arbiter: one host channel broadcast to four
 * tributaries, one tributary at a time granted toward the host,
 * antistreaming timeout, lockout and alarm, wishbone registers.
 * assumes: line pins asynchronous to clk_sys, wishbone on clk_sys, handshake levels are
 * active high here, data lines idle high; line drivers outside.
 */
// Register access over Wishbone and the register offsets were chosen for this implementation.
// Behaviour
// - four user channels plus cascade in and out, each DCE or DTE
// - host data broadcast to all tributaries with proper handshakes; disabled tributaries get neither here
// - only one tributary at a time may send to the host
// - data detection channels request by a start bit
// - data detection CTS on while idle, off when unavailable
// - antistreaming can be disabled per channel
// - DCE host RTS gives host CTS and tributary RTS or DCD
// - DCE host Tx goes to DCE trib Rx and DTE trib Tx
// - DCE host drops RTS, bridge drops CTS, RTS and DCD
// - DTE host DCD drives tributary lines, released on drop
// - DCE trib RTS granted with CTS when free and eligible
// - any grant turns CTS off on all data detection tributaries
// - DTE trib requests by DCD, release 4 ms after drop
// - granted trib data goes to host Rx or Tx pin
// - DCE trib drops RTS, release after 4 ms
// - start bit on eligible free channel gets the grant
// - data detection grant ends after 10 ms line idle
// - 3 s active with antistreaming: cut off and raise alarm
// - 400 ms lockout after timeout, counted once channel quiet
// - activity during lockout reloads the full 400 ms
// - per channel settings in, activity, disabled, alarm out
`timescale 1ns/10ps
`include "sda_map.vh"

module sda_arbiter #(
    parameter [19:0] REL_CYC    = `SDA_REL_CYC,
    parameter [21:0] IDLE_CYC   = `SDA_IDLE_CYC,
    parameter [29:0] STREAM_CYC = `SDA_STREAM_CYC,
    parameter [26:0] LOCK_CYC   = `SDA_LOCK_CYC
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        arst_n,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // host channel
    input  wire        hostRtsIn,
    input  wire        hostDcdIn,
    input  wire        hostTxIn,
    input  wire        hostRxIn,
    output reg         hostCtsOut,
    output reg         hostRtsOut,
    output reg         hostDcdOut,
    output reg         hostRxOut,
    output reg         hostTxOut,
    // tributary channels
    input  wire [3:0]  tribRtsIn,
    input  wire [3:0]  tribDcdIn,
    input  wire [3:0]  tribTxIn,
    input  wire [3:0]  tribRxIn,
    output reg  [3:0]  tribCtsOut,
    output reg  [3:0]  tribRtsOut,
    output reg  [3:0]  tribDcdOut,
    output reg  [3:0]  tribRxOut,
    output reg  [3:0]  tribTxOut,
    // cascade channels
    input  wire        casInReq,
    input  wire        casInData,
    output reg         casOutReq,
    output reg         casOutData,
    // panel
    output reg  [3:0]  lineStd232,
    output reg  [3:0]  ledActive,
    output reg  [3:0]  ledDisabled,
    output reg         ledAlarm,
    output reg         alarmRelay
);

// ==========================================================
// states
localparam [1:0] ST_IDLE  = 2'd0;
localparam [1:0] ST_GRANT = 2'd1;
localparam [1:0] ST_HOLD  = 2'd2;

// ==========================================================
// input synchronisers
wire [21:0] syncIn = {casInData, casInReq, hostRxIn, hostTxIn,
                      hostDcdIn, hostRtsIn, tribRxIn, tribTxIn,
                      tribDcdIn, tribRtsIn};
reg  [21:0] sync1_reg;
reg  [21:0] sync2_reg;

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        sync1_reg <= `SDA_SYNC_RST;
        sync2_reg <= `SDA_SYNC_RST;
    end else begin
        sync1_reg <= syncIn;
        sync2_reg <= sync1_reg;
    end
end

wire [3:0] sRts   = sync2_reg[3:0];
wire [3:0] sDcd   = sync2_reg[7:4];
wire [3:0] sTx    = sync2_reg[11:8];
wire [3:0] sRx    = sync2_reg[15:12];
wire       sHRts  = sync2_reg[16];
wire       sHDcd  = sync2_reg[17];
wire       sHTx   = sync2_reg[18];
wire       sHRx   = sync2_reg[19];
wire       sCReq  = sync2_reg[20];
wire       sCData = sync2_reg[21];

// ==========================================================
// configuration
reg  [31:0] cfg_reg;
reg         alarm_reg;
reg  [3:0]  lockOn_reg;

wire [3:0] cfgDte  = cfg_reg[`SDA_CFG_DTE +: 4];
wire [3:0] cfgStd  = cfg_reg[`SDA_CFG_STD +: 4];
wire [3:0] cfgStrm = cfg_reg[`SDA_CFG_STRM +: 4];
wire [3:0] cfgDd   = cfg_reg[`SDA_CFG_DD +: 4];
wire [3:0] cfgDis  = cfg_reg[`SDA_CFG_DIS +: 4];
wire       hostDte = cfg_reg[`SDA_CFG_HDTE];
wire [3:0] cfgEn   = ~cfgDis;

// ==========================================================
// per-source view; index 4 is the cascade input, which is a
// handshake source that is never disabled, locked or timed
wire [4:0] srcData = {sCData, (cfgDte & sRx) | (~cfgDte & sTx)};
wire [4:0] srcHs   = {sCReq, (cfgDte & sDcd) | (~cfgDte & sRts)};
wire [4:0] srcDd   = {1'b0, cfgDd};
wire [4:0] srcReq  = (srcDd & ~srcData) | (~srcDd & srcHs);
wire [4:0] srcOk   = {1'b1, cfgEn & ~lockOn_reg};
wire [4:0] contend = srcReq & srcOk;
wire [3:0] lineAct = ~sTx | ~sRx | sRts | sDcd;

reg  [2:0] pick;
integer    k;
always @* begin
    pick = 3'd0;
    for (k = 4; k >= 0; k = k - 1) begin
        if (contend[k]) begin
            pick = k[2:0];
        end
    end
end

// ==========================================================
// grant state machine
reg  [1:0]  state_reg;
reg  [1:0]  state_next;
reg  [2:0]  gIdx_reg;
reg  [21:0] relCnt_reg;
reg  [21:0] relCnt_next;
reg  [29:0] strmCnt_reg;
reg  [29:0] strmCnt_next;
reg         timeout;

wire granted = (state_reg != ST_IDLE);
wire gDd     = srcDd[gIdx_reg];
wire gHs     = srcHs[gIdx_reg];
wire gLow    = ~srcData[gIdx_reg];
wire gStrm   = (gIdx_reg < 3'd4) & cfgStrm[gIdx_reg[1:0]];
wire gDis    = (gIdx_reg < 3'd4) & cfgDis[gIdx_reg[1:0]];

always @* begin
    state_next   = state_reg;
    relCnt_next  = relCnt_reg + 22'd1;
    strmCnt_next = strmCnt_reg + 30'd1;
    timeout      = 1'b0;
    case (state_reg)
        ST_IDLE: begin
            relCnt_next  = 22'd0;
            strmCnt_next = 30'd0;
            if (|contend) begin
                state_next = ST_GRANT;
            end
        end
        ST_GRANT: begin
            if (gDd) begin
                // any space bit restarts the idle window
                if (gLow) begin
                    relCnt_next = 22'd0;
                end else if (relCnt_reg == IDLE_CYC - 22'd1) begin
                    state_next = ST_IDLE;
                end
            end else begin
                relCnt_next = 22'd0;
                if (!gHs) begin
                    state_next = ST_HOLD;
                end
            end
        end
        ST_HOLD: begin
            // request back inside the hold keeps the same grant
            if (gHs) begin
                state_next  = ST_GRANT;
                relCnt_next = 22'd0;
            end else if (relCnt_reg == {2'b00, REL_CYC} - 22'd1) begin
                state_next = ST_IDLE;
            end
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
    if (granted && gStrm && strmCnt_reg == STREAM_CYC - 30'd1) begin
        timeout    = 1'b1;
        state_next = ST_IDLE;
    end
    if (granted && gDis) begin
        state_next = ST_IDLE;
    end
end

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        state_reg   <= ST_IDLE;
        gIdx_reg    <= 3'd0;
        relCnt_reg  <= 22'd0;
        strmCnt_reg <= 30'd0;
    end else begin
        state_reg   <= state_next;
        relCnt_reg  <= relCnt_next;
        strmCnt_reg <= strmCnt_next;
        if (state_reg == ST_IDLE) begin
            gIdx_reg <= pick;
        end
    end
end

// ==========================================================
// lockout timers; the count only runs down while the channel
// is quiet, so a streaming device stays locked indefinitely
reg [26:0] lockCnt_reg [0:3];
integer    i;

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        lockOn_reg <= 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            lockCnt_reg[i] <= 27'd0;
        end
    end else begin
        for (i = 0; i < 4; i = i + 1) begin
            if (timeout && gIdx_reg == i[2:0]) begin
                lockOn_reg[i]  <= 1'b1;
                lockCnt_reg[i] <= LOCK_CYC;
            end else if (lockOn_reg[i]) begin
                if (cfgDd[i] ? (~sTx[i] | ~sRx[i]) : lineAct[i]) begin
                    lockCnt_reg[i] <= LOCK_CYC;
                end else if (lockCnt_reg[i] <= 27'd1) begin
                    lockOn_reg[i]  <= 1'b0;
                    lockCnt_reg[i] <= 27'd0;
                end else begin
                    lockCnt_reg[i] <= lockCnt_reg[i] - 27'd1;
                end
            end
        end
    end
end

// ==========================================================
// wishbone slave: one wait state, unmapped reads return zero
wire        wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
// writes land at the edge where the master samples ack high
wire        wbWr   = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
wire        alarmClr = wbWr & (wb_adr_i == `SDA_OFS_ACLR)
                     & wb_sel_i[0] & wb_dat_i[0];
reg  [31:0] cfgWr;
reg  [31:0] rdData;
integer     b;

always @* begin
    cfgWr = cfg_reg;
    for (b = 0; b < 4; b = b + 1) begin
        if (wb_sel_i[b]) begin
            cfgWr[b*8 +: 8] = wb_dat_i[b*8 +: 8];
        end
    end
    cfgWr = cfgWr & `SDA_CFG_MASK;
end

always @* begin
    rdData = 32'h0;
    case (wb_adr_i)
        `SDA_OFS_CFG: begin
            rdData = cfg_reg;
        end
        `SDA_OFS_STAT: begin
            rdData[`SDA_ST_LOCK +: 4] = lockOn_reg;
            rdData[`SDA_ST_GNT]       = granted;
            rdData[`SDA_ST_GIDX +: 3] = gIdx_reg;
            rdData[`SDA_ST_ALARM]     = alarm_reg;
            rdData[`SDA_ST_ACT +: 4]  = lineAct;
        end
        default: begin
            rdData = 32'h0;
        end
    endcase
end

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        cfg_reg   <= `SDA_CFG_RST;
        alarm_reg <= 1'b0;
        wb_ack_o  <= 1'b0;
        wb_dat_o  <= 32'h0;
    end else begin
        wb_ack_o <= wbReq;
        wb_dat_o <= (wbReq & ~wb_we_i) ? rdData : 32'h0;
        if (wbWr && wb_adr_i == `SDA_OFS_CFG) begin
            cfg_reg <= cfgWr;
        end
        // a timeout in the clearing cycle keeps the alarm set
        alarm_reg <= timeout | (alarm_reg & ~alarmClr);
    end
end

// ==========================================================
// line outputs, all registered
wire       hostSend = hostDte ? sHDcd : sHRts;
wire       bData    = hostDte ? sHRx : sHTx;
wire [3:0] bLow     = {4{~bData}} & cfgEn;
wire [3:0] gOh      = granted ? (4'h1 << gIdx_reg[1:0]) & {4{~gIdx_reg[2]}}
                              : 4'h0;
wire       gData    = granted ? srcData[gIdx_reg] : 1'b1;

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        hostCtsOut  <= 1'b0;
        hostRtsOut  <= 1'b0;
        hostDcdOut  <= 1'b0;
        hostRxOut   <= 1'b1;
        hostTxOut   <= 1'b1;
        tribCtsOut  <= 4'h0;
        tribRtsOut  <= 4'h0;
        tribDcdOut  <= 4'h0;
        tribRxOut   <= 4'hf;
        tribTxOut   <= 4'hf;
        casOutReq   <= 1'b0;
        casOutData  <= 1'b1;
        lineStd232  <= 4'h0;
        ledActive   <= 4'h0;
        ledDisabled <= 4'h0;
        ledAlarm    <= 1'b0;
        alarmRelay  <= 1'b0;
    end else begin
        hostCtsOut <= ~hostDte & sHRts;
        hostDcdOut <= ~hostDte & granted;
        hostRtsOut <= hostDte & granted;
        hostRxOut  <= hostDte | gData;
        hostTxOut  <= ~hostDte | gData;
        tribRtsOut <= cfgEn & cfgDte & {4{hostSend}};
        tribDcdOut <= cfgEn & ~cfgDte & {4{hostSend}};
        tribRxOut  <= ~(bLow & ~cfgDte);
        tribTxOut  <= ~(bLow & cfgDte);
        // dte handshake channels never get CTS; a locked channel
        // loses its grant, so its CTS falls as well
        tribCtsOut <= (gOh & ~cfgDd & ~cfgDte)
                    | (cfgDd & cfgEn & ~lockOn_reg
                       & {4{~granted}});
        casOutReq  <= hostSend;
        casOutData <= bData;
        lineStd232  <= cfgStd;
        ledActive   <= lineAct;
        ledDisabled <= cfgDis;
        ledAlarm    <= alarm_reg;
        alarmRelay  <= alarm_reg;
    end
end

endmodule

// ### tb/sda_arbiter_chk.sv
/*
 * port checker of the arbiter: bus answer, host handshake, routing.
 * assumes one clock domain and active high handshakes.
 */
`timescale 1ns/10ps
// ====================
// checker
module sda_arbiter_chk (
    // clock and reset
    input wire        clk_sys,
    input wire        arst_n,
    // wishbone
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // channels
    input wire        hostRtsIn,
    input wire        hostCtsOut,
    input wire        hostDcdOut,
    input wire        hostRtsOut,
    input wire        hostRxOut,
    input wire        hostTxOut,
    input wire [3:0]  tribTxIn,
    input wire [3:0]  tribCtsOut,
    input wire        ledAlarm,
    input wire        alarmRelay
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire gntNow = hostDcdOut || hostRtsOut;

    a_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_dat_quiet: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
    a_host_excl: assert property (
        hostRtsOut |-> !hostDcdOut && !hostCtsOut)
        else $error("host lines mixed");
    a_cts_raise: assert property (
        $rose(hostCtsOut) |-> $past(hostRtsIn, 3))
        else $error("host cts without rts");
    a_cts_drop: assert property (
        $fell(hostCtsOut) |-> !$past(hostRtsIn, 3))
        else $error("host cts dropped early");
    a_gnt_data: assert property (
        (hostDcdOut && tribCtsOut[0]) [*5]
        |-> hostRxOut == $past(tribTxIn[0], 3))
        else $error("granted data lost");
    a_quiet_lines: assert property (
        (!gntNow) [*2] |-> hostRxOut && hostTxOut)
        else $error("host line busy without grant");
    a_alarm_relay: assert property (
        alarmRelay == ledAlarm) else $error("relay and alarm differ");
endmodule

bind sda_arbiter sda_arbiter_chk chk (.*);

// ### tb/sda_trib_model.sv
/*
 * tributary device: asks by handshake or start bit, then sends
 * alternating bits; assumes the bench sets its mode.
 */
`timescale 1ns/10ps
// ====================
// tributary model
module sda_trib_model (
    // clock and command
    input wire  clk_sys,
    input wire  want,
    input wire  hsMode,
    input wire  dteMode,
    // lines toward the bridge
    input wire  ctsIn,
    output reg  rtsOut = 1'b0,
    output reg  dcdOut = 1'b0,
    output wire txOut,
    output wire rxOut
);
    reg sending = 1'b0;
    reg dataBit = 1'b1;
    always @(posedge clk_sys) begin
        sending <= want && (sending || hsMode || ctsIn);
        rtsOut <= want && hsMode && !dteMode;
        dcdOut <= want && hsMode && dteMode;
        dataBit <= sending ? ~dataBit : 1'b1;
    end
    // idle line rests at mark so a stop reads as idle
    assign txOut = dteMode ? 1'b1 : dataBit;
    assign rxOut = dteMode ? dataBit : 1'b1;
endmodule

// ### tb/sda_arbiter_tb_top.sv
/*
 * bench of the arbiter: registers, broadcast, grants, lockout.
 * assumes the shortened counts set at the instance.
 */
`timescale 1ns/10ps
// ====================
// bench
module sda_arbiter_tb_top;
    localparam integer REL = 20;
    localparam integer IDLE = 40;
    // std 6, antistream ch0, detect ch2-3, ch3 off, dte ch1 ch3
    localparam [31:0]  CFG = 32'h0008c16a;
    reg        clk_sys = 1'b0;
    reg        arst_n = 1'b0;
    reg        wb_cyc_i = 1'b0;
    reg        wb_stb_i = 1'b0;
    reg        wb_we_i = 1'b0;
    reg [7:0]  wb_adr_i = 8'h00;
    reg [31:0] wb_dat_i = 32'h0;
    reg        hostRtsIn = 1'b0;
    reg        hostTxIn = 1'b1;
    reg [3:0]  want = 4'h0;
    reg [7:0]  seed = 8'h1b;
    // cascade unused
    wire [3:0] wb_sel_i = 4'hf;
    reg        hostDcdIn = 1'b0;
    reg        hostRxIn = 1'b1;
    reg        bitNow = 1'b1;
    wire       casInReq = 1'b0;
    wire       casInData = 1'b1;
    wire [31:0] wb_dat_o;
    wire       wb_ack_o, hostCtsOut, hostRtsOut, hostDcdOut;
    wire       hostRxOut, hostTxOut, casOutReq, casOutData;
    wire       ledAlarm, alarmRelay;
    wire [3:0] tribRtsIn, tribDcdIn, tribTxIn, tribRxIn;
    wire [3:0] tribCtsOut, tribRtsOut, tribDcdOut, tribRxOut;
    wire [3:0] tribTxOut, lineStd232, ledActive, ledDisabled;
    integer    err_count = 0;
    integer    cmp_count = 0;
    reg [31:0] expQ[$];

    sda_arbiter #(
        .REL_CYC    (20'd20),
        .IDLE_CYC   (22'd40),
        .STREAM_CYC (30'd200),
        .LOCK_CYC   (27'd50)
    ) dut (.*);

    sda_trib_model trib[3:0] (
        .clk_sys (clk_sys),
        .want    (want),
        .hsMode  (~CFG[15:12]),
        .dteMode (CFG[3:0]),
        .ctsIn   (tribCtsOut),
        .rtsOut  (tribRtsIn),
        .dcdOut  (tribDcdIn),
        .txOut   (tribTxIn),
        .rxOut   (tribRxIn)
    );

    always #2 clk_sys = ~clk_sys;

    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task complete_run;
        begin
            $display("compared %0d, mismatched %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    task automatic chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: %h vs %h", $time, got, exp);
            end
        end
    endtask

    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one classic cycle; reads note their expected word first
    task wbx(input [7:0] a, input w, input [31:0] d, input [31:0] e);
        integer n;
        begin
            if (!w)
                expQ.push_back(e);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            n = 0;
            @(posedge clk_sys);
            while (wb_ack_o !== 1'b1 && n < 16) begin
                n = n + 1;
                @(posedge clk_sys);
            end
            if (n == 16) begin
                err_count = err_count + 1;
                complete_run;
            end
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    always @(posedge clk_sys) begin
        if (wb_ack_o === 1'b1 && !wb_we_i) begin
            if (expQ.size() > 0)
                chk(wb_dat_o, expQ.pop_front());
            else
                chk(32'h1, 32'h0);
        end
    end

    initial begin
        tick(3);
        arst_n <= 1'b1;
        tick(1);
        wbx(8'h00, 1'b0, 32'h0, 32'h0);
        wbx(8'h0c, 1'b0, 32'h0, 32'h0);
        wbx(8'h00, 1'b1, CFG, 32'h0);
        wbx(8'h00, 1'b0, 32'h0, CFG);
        tick(4);
        chk(tribCtsOut, 4'h4);
        chk(ledDisabled, 4'h8);
        chk(lineStd232, 4'h6);
        $display("registers done");
        hostRtsIn <= 1'b1;
        tick(6);
        chk({hostCtsOut, casOutReq, tribRtsOut, tribDcdOut}, 10'h325);
        repeat (8) begin
            seed = lfsr(seed);
            hostTxIn <= seed[0];
            tick(6);
            chk(tribRxOut, {1'b1, seed[0], 1'b1, seed[0]});
            chk(tribTxOut, {2'b11, seed[0], 1'b1});
            chk(casOutData, seed[0]);
        end
        hostRtsIn <= 1'b0;
        hostTxIn <= 1'b1;
        tick(6);
        chk({hostCtsOut, casOutReq, tribRtsOut, tribDcdOut}, 10'h0);
        $display("broadcast done");
        want <= 4'h3;
        tick(8);
        chk({hostDcdOut, tribCtsOut}, 5'h11);
        chk(ledActive, 4'h3);
        want <= 4'h2;
        tick(REL - 5);
        chk(tribCtsOut, 4'h1);
        tick(20);
        chk({hostDcdOut, tribCtsOut}, 5'h10);
        want <= 4'h0;
        tick(REL + 10);
        chk({hostDcdOut, tribCtsOut}, 5'h04);
        $display("handshake grants done");
        want <= 4'h4;
        tick(250);
        chk({hostDcdOut, tribCtsOut}, 5'h10);
        chk(ledAlarm, 1'b0);
        want <= 4'h0;
        tick(IDLE - 10);
        chk(hostDcdOut, 1'b1);
        tick(20);
        chk({hostDcdOut, tribCtsOut}, 5'h04);
        $display("data detect done");
        want <= 4'h1;
        tick(250);
        chk({ledAlarm, alarmRelay, hostDcdOut, tribCtsOut}, 7'h64);
        want <= 4'h0;
        tick(30);
        want <= 4'h1;
        tick(3);
        want <= 4'h0;
        tick(30);
        want <= 4'h1;
        tick(8);
        chk(hostDcdOut, 1'b0);
        want <= 4'h0;
        tick(70);
        want <= 4'h1;
        tick(8);
        chk({hostDcdOut, tribCtsOut}, 5'h11);
        want <= 4'h0;
        tick(REL + 10);
        wbx(8'h08, 1'b1, 32'h1, 32'h0);
        tick(2);
        chk(ledAlarm, 1'b0);
        $display("antistreaming done");
        // host turned dte: sends by dcd, data on its rx line
        wbx(8'h00, 1'b1, CFG | 32'h00100000, 32'h0);
        hostDcdIn <= 1'b1;
        hostRxIn <= 1'b0;
        tick(6);
        chk({tribRtsOut, tribDcdOut, tribRxOut, tribTxOut}, 16'h25ad);
        chk({casOutReq, casOutData}, 2'h2);
        want <= 4'h2;
        tick(8);
        chk({hostRtsOut, hostDcdOut, hostCtsOut, hostRxOut}, 4'h9);
        // sample off the edge: the pin bit reaches hostTxOut 3 edges on
        @(negedge clk_sys);
        bitNow = tribRxIn[1];
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(hostTxOut, bitNow);
        tick(1);
        want <= 4'h0;
        hostDcdIn <= 1'b0;
        hostRxIn <= 1'b1;
        tick(REL + 10);
        chk({hostRtsOut, tribRtsOut, tribDcdOut}, 9'h0);
        $display("dte host done");
        complete_run;
    end
endmodule
